// file: logic/pdt_pkg.sv
package pdt_pkg;

  // ------------------------------------------------------------------
  // Bus and data widths
  // ------------------------------------------------------------------
  localparam int PDT_DATA_W   = 32;
  localparam int PDT_ADDR_W   = 8;
  localparam int PDT_SAMPLE_W = 14;
  localparam int PDT_THR_W    = 7;
  localparam int PDT_CNT_W    = 8;
  localparam int PDT_AXES     = 3;

  // ------------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ------------------------------------------------------------------
  localparam logic [5:0] PDT_IDX_THR_X      = 6'h23;
  localparam logic [5:0] PDT_IDX_THR_Y      = 6'h24;
  localparam logic [5:0] PDT_IDX_THR_Z      = 6'h25;
  localparam logic [5:0] PDT_IDX_TIME_LIMIT = 6'h26;
  localparam logic [5:0] PDT_IDX_LATENCY    = 6'h27;
  localparam logic [5:0] PDT_IDX_HIGHPASS   = 6'h2A;
  localparam logic [5:0] PDT_IDX_RANGE      = 6'h2B;
  localparam logic [5:0] PDT_IDX_OVERSAMPLE = 6'h2C;
  localparam logic [5:0] PDT_IDX_RATE       = 6'h2D;
  localparam logic [5:0] PDT_IDX_IRQ_STATUS = 6'h2E;
  localparam logic [5:0] PDT_IDX_IRQ_MASK   = 6'h2F;
  localparam logic [5:0] PDT_IDX_STATE      = 6'h30;

  // ------------------------------------------------------------------
  // Reset values and field positions
  // ------------------------------------------------------------------
  localparam logic [7:0] PDT_RESET_BYTE = 8'h00;
  localparam logic [2:0] PDT_RESET_IRQ  = 3'h0;
  localparam int PDT_HPF_EN_BIT  = 0;
  localparam int PDT_STATE_BUSY  = 3;
  localparam int PDT_THR_LSB_POS = 6;

  localparam logic [1:0] PDT_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PDT_RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------------
  // Timing: base step is the shortest time step of any mode
  // ------------------------------------------------------------------
  localparam int PDT_CLK_PERIOD_NS = 20;
  localparam int PDT_BASE_STEP_NS  = 625000;
  localparam int PDT_BASE_STEP_CYCLES =
    (PDT_BASE_STEP_NS + PDT_CLK_PERIOD_NS - 1) / PDT_CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    PDT_NORMAL,
    PDT_LOW_POWER_LOW_NOISE,
    PDT_HIGH_RES,
    PDT_LOW_POWER
  } pdt_power_mode_t;

  typedef enum logic [1:0] {
    PDT_RANGE_2G,
    PDT_RANGE_4G,
    PDT_RANGE_8G
  } pdt_range_t;

  // Time-limit step as a power of two of the base step, indexed by
  // {filter enable, power mode}; one nibble per rate code, 800 Hz lowest.
  // The latency step is always one power of two larger.
  localparam logic [31:0] PDT_STEP_EXP [8] = '{
    32'h33332100, 32'h55532100, 32'h00000000, 32'h66643210,
    32'h55554321, 32'h77754321, 32'h22222221, 32'h88754321
  };

endpackage

// file: logic/pdt_axis.sv
`timescale 1ns/1ps
module pdt_axis
  import pdt_pkg::*;
#(
  parameter int SAMPLE_W = PDT_SAMPLE_W
)
(
  input  wire logic                 ref_clk,
  input  wire logic                 srst,
  input  wire logic                 base_tick,
  input  wire logic                 sample_valid,
  input  wire logic [SAMPLE_W-1:0]  sample,
  input  wire logic [1:0]           full_scale_select,
  input  wire logic [PDT_THR_W-1:0] threshold,
  input  wire logic [PDT_CNT_W-1:0] time_limit,
  input  wire logic [PDT_CNT_W-1:0] latency,
  input  wire logic [3:0]           step_exp,
  output logic                      pulse_event,
  output logic                      pulse_negative,
  output logic                      busy
);

  typedef enum logic [1:0] {PDT_IDLE, PDT_HIGH, PDT_OVER, PDT_LATENT} pdt_axis_state_t;

  pdt_axis_state_t      state;
  pdt_axis_state_t      next_state;
  logic [9:0]           sub_cnt;
  logic [PDT_CNT_W-1:0] step_cnt;

  // ------------------------------------------------------------------
  // Threshold compare on an 8 g basis
  // ------------------------------------------------------------------
  wire              negative    = sample[SAMPLE_W-1];
  wire [SAMPLE_W-1:0] magnitude = negative ? SAMPLE_W'(-sample) : sample;
  wire [1:0] scale_shift = (full_scale_select == PDT_RANGE_2G) ? 2'h2 :
                           (full_scale_select == PDT_RANGE_4G) ? 2'h1 : 2'h0;
  wire [SAMPLE_W-1:0] mag_8g = magnitude >> scale_shift;
  wire above = mag_8g[SAMPLE_W-1:PDT_THR_LSB_POS] >
               (SAMPLE_W-PDT_THR_LSB_POS)'(threshold);

  // ------------------------------------------------------------------
  // Time step: latency steps are twice the time-limit steps
  // ------------------------------------------------------------------
  wire [3:0] cur_exp  = (state == PDT_LATENT) ? 4'(step_exp + 4'h1) : step_exp;
  wire [9:0] step_len = 10'h001 << cur_exp;
  // Compare with >= so a shorter step after a mode change cannot strand the divider
  wire step_tick   = base_tick && (sub_cnt >= 10'(step_len - 10'h001));
  wire limit_done  = (step_cnt >= time_limit);
  wire latency_done = (step_cnt >= latency);
  wire restart     = (next_state != state);

  always_comb
  begin
    next_state = state;
    case (state)
      PDT_IDLE:
        if (sample_valid && above)
          next_state = PDT_HIGH;
      PDT_HIGH:
        if (limit_done)
          next_state = PDT_OVER;
        else if (sample_valid && !above)
          next_state = PDT_LATENT;
      PDT_OVER:
        if (sample_valid && !above)
          next_state = PDT_IDLE;
      PDT_LATENT:
        if (latency_done)
          next_state = PDT_IDLE;
      default:
        next_state = PDT_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state          <= PDT_IDLE;
      sub_cnt        <= 10'h000;
      step_cnt       <= 8'h00;
      pulse_event    <= 1'b0;
      pulse_negative <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      pulse_event <= (state == PDT_HIGH) && (next_state == PDT_LATENT);
      if (state == PDT_IDLE && next_state == PDT_HIGH)
        pulse_negative <= negative;
      if (restart)
      begin
        sub_cnt  <= 10'h000;
        step_cnt <= 8'h00;
      end
      else if (base_tick)
      begin
        sub_cnt <= step_tick ? 10'h000 : 10'(sub_cnt + 10'h001);
        // Saturate so a long excursion cannot wrap back under the limit
        if (step_tick && step_cnt != 8'hFF)
          step_cnt <= 8'(step_cnt + 8'h01);
      end
    end
  end

  assign busy = (state != PDT_IDLE);

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_crossing;
    state == PDT_IDLE && sample_valid && above;
  endsequence

  sequence s_timing;
    state == PDT_HIGH && step_cnt == 8'h00;
  endsequence

  property p_start_on_cross;
    @(posedge ref_clk) disable iff (srst) s_crossing |=> s_timing;
  endproperty
  a_start_on_cross: assert property (p_start_on_cross)
    else $error("crossing did not start pulse timing");

  property p_long_not_pulse;
    @(posedge ref_clk) disable iff (srst)
      state == PDT_HIGH && limit_done |=> !pulse_event ##1 !pulse_event;
  endproperty
  a_long_not_pulse: assert property (p_long_not_pulse)
    else $error("over-long excursion reported as pulse");

  property p_zero_limit;
    @(posedge ref_clk) disable iff (srst)
      s_timing and time_limit == 8'h00 |=> state == PDT_OVER;
  endproperty
  a_zero_limit: assert property (p_zero_limit)
    else $error("zero time limit did not expire at once");

  property p_step_bound;
    @(posedge ref_clk) disable iff (srst)
      base_tick && !restart && sub_cnt >= 10'(step_len - 10'h001) |=> sub_cnt == 10'h000;
  endproperty
  a_step_bound: assert property (p_step_bound)
    else $error("step divider did not wrap at the step length");

  property p_latency_ignore;
    @(posedge ref_clk) disable iff (srst)
      state == PDT_LATENT && !latency_done |=> state != PDT_HIGH;
  endproperty
  a_latency_ignore: assert property (p_latency_ignore)
    else $error("new pulse started inside latency");

  property p_latency_step;
    @(posedge ref_clk) disable iff (srst)
      state == PDT_LATENT |-> step_len == (10'h002 << step_exp);
  endproperty
  a_latency_step: assert property (p_latency_step)
    else $error("latency step not twice the time-limit step");

endmodule

// file: logic/pdt_core.sv
// Overview of operation
// - Each axis holds its own unsigned 7-bit threshold, 0.063 g per count.
// - Threshold compare always uses an 8 g basis, whatever the range setting.
// - An axis starts pulse detection when its acceleration exceeds its threshold.
// - Time-limit count bounds the above-threshold excursion; longer ones are no pulse.
// - Time-limit count is applied in units of the mode-dependent time step.
// - Filter on: time-limit step 1.25 ms at 800 Hz, scaled by rate and mode.
// - Filter off: time-limit steps as printed, 0.625 ms at 800 Hz, 40 ms max.
// - After a pulse, new pulse starts are ignored for the latency count of steps.
// - Latency count is applied in units of the latency time step.
// - Filter on: latency step 2.5 ms at 800 Hz, scaled by rate and mode.
// - Filter off: latency steps 1.25 ms at 800 Hz, 80 ms max.
`timescale 1ns/1ps
module pdt_core
  import pdt_pkg::*;
#(
  parameter int BASE_STEP_CYCLES = PDT_BASE_STEP_CYCLES,
  parameter int SAMPLE_W         = PDT_SAMPLE_W
)
(
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  input  wire logic [PDT_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [PDT_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [PDT_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [PDT_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  accel_valid,
  input  wire logic [SAMPLE_W-1:0]   accel_x,
  input  wire logic [SAMPLE_W-1:0]   accel_y,
  input  wire logic [SAMPLE_W-1:0]   accel_z,
  output logic                       irq
);

  // ------------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------------
  logic [7:0]          pulse_threshold [PDT_AXES];
  logic [7:0]          pulse_time_limit;
  logic [7:0]          pulse_latency;
  logic [7:0]          highpass_config_reg;
  logic [7:0]          range_config_reg;
  logic [7:0]          oversample_control_reg;
  logic [7:0]          rate_config_reg;
  logic [PDT_AXES-1:0] irq_status;
  logic [PDT_AXES-1:0] irq_mask;

  logic [PDT_ADDR_W-1:0] aw_addr_q;
  logic [7:0]            w_data_q;
  logic                  w_lane0_q;
  logic                  aw_hold;
  logic                  w_hold;

  logic [PDT_AXES-1:0] axis_event;
  logic [PDT_AXES-1:0] axis_negative;
  logic [PDT_AXES-1:0] axis_busy;
  wire [SAMPLE_W-1:0]  axis_sample [PDT_AXES];

  assign axis_sample[0] = accel_x;
  assign axis_sample[1] = accel_y;
  assign axis_sample[2] = accel_z;

  // ------------------------------------------------------------------
  // AXI4-Lite write path: address and data taken in either order
  // ------------------------------------------------------------------
  assign s_axi_awready = !aw_hold;
  assign s_axi_wready  = !w_hold;

  wire       wr_fire = aw_hold && w_hold && !s_axi_bvalid;
  wire [5:0] wr_idx  = aw_addr_q[7:2];
  wire       wr_en   = wr_fire && w_lane0_q;

  wire wr_mapped = (wr_idx >= PDT_IDX_THR_X && wr_idx <= PDT_IDX_LATENCY) ||
                   (wr_idx >= PDT_IDX_HIGHPASS && wr_idx <= PDT_IDX_STATE);

  wire                wr_clr_irq = wr_en && (wr_idx == PDT_IDX_IRQ_STATUS);
  wire [PDT_AXES-1:0] irq_clear  = wr_clr_irq ? w_data_q[PDT_AXES-1:0] : PDT_RESET_IRQ;
  // A pulse in the same cycle as its clear is kept
  wire [PDT_AXES-1:0] next_irq_status = (irq_status & ~irq_clear) | axis_event;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      aw_addr_q    <= '0;
      w_data_q     <= PDT_RESET_BYTE;
      w_lane0_q    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= PDT_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold   <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_hold <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold    <= 1'b1;
        w_data_q  <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end
      else if (wr_fire)
        w_hold <= 1'b0;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? PDT_RESP_OKAY : PDT_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pulse_time_limit       <= PDT_RESET_BYTE;
      pulse_latency          <= PDT_RESET_BYTE;
      highpass_config_reg    <= PDT_RESET_BYTE;
      range_config_reg       <= PDT_RESET_BYTE;
      oversample_control_reg <= PDT_RESET_BYTE;
      rate_config_reg        <= PDT_RESET_BYTE;
      irq_status             <= PDT_RESET_IRQ;
      irq_mask               <= PDT_RESET_IRQ;
    end
    else
    begin
      irq_status <= next_irq_status;
      if (wr_en)
      begin
        case (wr_idx)
          PDT_IDX_TIME_LIMIT: pulse_time_limit       <= w_data_q;
          PDT_IDX_LATENCY:    pulse_latency          <= w_data_q;
          PDT_IDX_HIGHPASS:   highpass_config_reg    <= w_data_q;
          PDT_IDX_RANGE:      range_config_reg       <= w_data_q;
          PDT_IDX_OVERSAMPLE: oversample_control_reg <= w_data_q;
          PDT_IDX_RATE:       rate_config_reg        <= w_data_q;
          PDT_IDX_IRQ_MASK:   irq_mask               <= w_data_q[PDT_AXES-1:0];
          default:            irq_mask               <= irq_mask;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite read path: answer one cycle after the address is taken
  // ------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  wire [5:0] rd_idx = s_axi_araddr[7:2];
  wire [7:0] state_byte = {2'h0, axis_busy, axis_negative};
  wire [7:0] rd_byte =
    (rd_idx == PDT_IDX_THR_X)      ? pulse_threshold[0] :
    (rd_idx == PDT_IDX_THR_Y)      ? pulse_threshold[1] :
    (rd_idx == PDT_IDX_THR_Z)      ? pulse_threshold[2] :
    (rd_idx == PDT_IDX_TIME_LIMIT) ? pulse_time_limit :
    (rd_idx == PDT_IDX_LATENCY)    ? pulse_latency :
    (rd_idx == PDT_IDX_HIGHPASS)   ? highpass_config_reg :
    (rd_idx == PDT_IDX_RANGE)      ? range_config_reg :
    (rd_idx == PDT_IDX_OVERSAMPLE) ? oversample_control_reg :
    (rd_idx == PDT_IDX_RATE)       ? rate_config_reg :
    (rd_idx == PDT_IDX_IRQ_STATUS) ? {5'h00, irq_status} :
    (rd_idx == PDT_IDX_IRQ_MASK)   ? {5'h00, irq_mask} :
    (rd_idx == PDT_IDX_STATE)      ? state_byte : PDT_RESET_BYTE;
  wire rd_mapped = (rd_idx >= PDT_IDX_THR_X && rd_idx <= PDT_IDX_LATENCY) ||
                   (rd_idx >= PDT_IDX_HIGHPASS && rd_idx <= PDT_IDX_STATE);

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= PDT_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= rd_mapped ? PDT_RESP_OKAY : PDT_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  assign irq = |(irq_status & irq_mask);

  // ------------------------------------------------------------------
  // Base step divider and mode-dependent step selection
  // ------------------------------------------------------------------
  localparam int BASE_W = $clog2(BASE_STEP_CYCLES + 1);
  localparam logic [BASE_W-1:0] BASE_LAST = BASE_W'(BASE_STEP_CYCLES - 1);

  logic [BASE_W-1:0] base_cnt;
  wire               base_tick = (base_cnt == BASE_LAST);

  always_ff @(posedge ref_clk)
  begin
    if (srst || base_tick)
      base_cnt <= '0;
    else
      base_cnt <= BASE_W'(base_cnt + 1'b1);
  end

  wire        hpf_en    = highpass_config_reg[PDT_HPF_EN_BIT];
  wire [1:0]  power_mode = oversample_control_reg[1:0];
  wire [2:0]  rate_code = rate_config_reg[2:0];
  wire [31:0] exp_row   = PDT_STEP_EXP[{hpf_en, power_mode}];
  wire [3:0]  step_exp  = exp_row[{rate_code, 2'h0} +: 4];

  // ------------------------------------------------------------------
  // Per-axis detectors
  // ------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PDT_AXES; gi++)
    begin : g_axis
      wire thr_wr = wr_en && (wr_idx == 6'(PDT_IDX_THR_X + gi));

      always_ff @(posedge ref_clk)
      begin
        if (srst)
          pulse_threshold[gi] <= PDT_RESET_BYTE;
        else if (thr_wr)
          pulse_threshold[gi] <= w_data_q;
      end

      pdt_axis #(
        .SAMPLE_W (SAMPLE_W)
      ) u_axis (
        .ref_clk           (ref_clk),
        .srst              (srst),
        .base_tick         (base_tick),
        .sample_valid      (accel_valid),
        .sample            (axis_sample[gi]),
        .full_scale_select (range_config_reg[1:0]),
        .threshold         (pulse_threshold[gi][PDT_THR_W-1:0]),
        .time_limit        (pulse_time_limit),
        .latency           (pulse_latency),
        .step_exp          (step_exp),
        .pulse_event       (axis_event[gi]),
        .pulse_negative    (axis_negative[gi]),
        .busy              (axis_busy[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_step_hpf_high_res;
    @(posedge ref_clk) disable iff (srst)
      hpf_en && power_mode == PDT_HIGH_RES && rate_code != 3'h0 |-> step_exp == 4'h2;
  endproperty
  a_step_hpf_high_res: assert property (p_step_hpf_high_res)
    else $error("high-resolution step with filter is not 2.5 ms");

  property p_step_nohpf_low_power;
    @(posedge ref_clk) disable iff (srst)
      !hpf_en && power_mode == PDT_LOW_POWER && rate_code >= 3'h5 |-> step_exp == 4'h6;
  endproperty
  a_step_nohpf_low_power: assert property (p_step_nohpf_low_power)
    else $error("low-power step without filter is not 40 ms");

  property p_latency_step_max;
    @(posedge ref_clk) disable iff (srst)
      hpf_en && power_mode == PDT_LOW_POWER && rate_code >= 3'h6 |-> step_exp == 4'h8;
  endproperty
  a_latency_step_max: assert property (p_latency_step_max)
    else $error("slowest low-power latency step is not 320 ms");

  property p_event_sticky;
    @(posedge ref_clk) disable iff (srst)
      |axis_event |=> (irq_status & $past(axis_event)) == $past(axis_event);
  endproperty
  a_event_sticky: assert property (p_event_sticky)
    else $error("pulse event lost from status");

endmodule

// file: dv/pdt_accel_src.sv
`timescale 1ns/1ps
module pdt_accel_src
  import pdt_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    srst,
  input  wire logic [2:0]              level_hi,
  output logic                         accel_valid,
  output logic [PDT_SAMPLE_W-1:0]      accel_x,
  output logic [PDT_SAMPLE_W-1:0]      accel_y,
  output logic [PDT_SAMPLE_W-1:0]      accel_z
);
  // ------------------------------------------------------------------
  // Sample stream
  // ------------------------------------------------------------------
  // A strobe every second cycle keeps pulse edges a sample apart
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      accel_valid <= 1'b0;
    end
    else
    begin
      accel_valid <= !accel_valid;
    end
    accel_x <= level_hi[0] ? 14'h1FFF : 14'h0000;
    accel_y <= level_hi[1] ? 14'h1FFF : 14'h0000;
    accel_z <= level_hi[2] ? 14'h1FFF : 14'h0000;
  end
endmodule

// file: dv/pulse_detect_threshold_timing_tb_top.sv
`timescale 1ns/1ps
module pulse_detect_threshold_timing_tb_top
  import pdt_pkg::*;
;
  logic ref_clk = 1'b0, srst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, irq, av;
  logic [1:0] bresp, rresp;
  logic [13:0] ax, ay, az;
  logic [2:0] hi = 3'h0;
  logic [31:0] rd;
  logic [1:0] rs;
  int mismatches = 0, compares = 0, cycles = 0;

  always #10 ref_clk = !ref_clk;

  pdt_accel_src SRC (.ref_clk(ref_clk), .srst(srst), .level_hi(hi), .accel_valid(av),
    .accel_x(ax), .accel_y(ay), .accel_z(az));

  pdt_core #(.BASE_STEP_CYCLES(4)) DUT (.ref_clk(ref_clk), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .accel_valid(av), .accel_x(ax), .accel_y(ay), .accel_z(az), .irq(irq));

  // ------------------------------------------------------------------
  // Bus and check helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    fork
      begin do @(posedge ref_clk); while (!awready); awvalid <= 1'b0; end
      begin do @(posedge ref_clk); while (!wready); wvalid <= 1'b0; end
    join
    while (!bvalid) @(posedge ref_clk);
    rs = bresp;
    bready <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rdr(input logic [7:0] a);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (!rvalid);
    rd = rdata; rs = rresp;
    rready <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Raise the chosen axes for n cycles, then let the result settle
  task automatic pulse(input logic [2:0] axes, input int n, input logic [31:0] exp);
    hi <= axes;
    repeat (n) @(posedge ref_clk);
    hi <= 3'h0;
    repeat (12) @(posedge ref_clk);
    rdr(8'hB8);
    chk(rd, exp);
    chk({31'h0, irq}, {31'h0, |exp[2:0]});
    wr(8'hB8, 8'h07);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_regs();
    for (int i = 0; i < 5; i++)
    begin
      rdr(8'h8C + 8'(4 * i));
      chk(rd, 32'h0);
      wr(8'h8C + 8'(4 * i), 8'(8'h11 * (i + 1)));
      rdr(8'h8C + 8'(4 * i));
      chk(rd, 32'(8'h11 * (i + 1)));
    end
    rdr(8'h04);
    chk(rd, 32'h0);
    chk({30'h0, rs}, {30'h0, PDT_RESP_SLVERR});
    wr(8'h04, 8'hFF);
    chk({30'h0, rs}, {30'h0, PDT_RESP_SLVERR});
  endtask

  task automatic t_axes();
    wr(8'hBC, 8'h07);
    wr(8'h98, 8'h0A);
    wr(8'h9C, 8'h00);
    pulse(3'h7, 8, 32'h1);
    wr(8'h94, 8'h08);
    pulse(3'h7, 8, 32'h5);
  endtask

  task automatic t_limit();
    wr(8'h98, 8'h02);
    pulse(3'h1, 40, 32'h0);
    pulse(3'h1, 4, 32'h1);
    wr(8'h98, 8'h00);
    pulse(3'h1, 4, 32'h0);
    wr(8'h98, 8'h0A);
  endtask

  task automatic t_latency();
    wr(8'h9C, 8'h14);
    pulse(3'h1, 8, 32'h1);
    pulse(3'h1, 8, 32'h0);
    repeat (200) @(posedge ref_clk);
    pulse(3'h1, 8, 32'h1);
  endtask

  // Range, filter and mode settings, then a mid-run reset
  task automatic t_modes();
    wr(8'h9C, 8'h00);
    wr(8'hAC, 8'h02);
    pulse(3'h2, 8, 32'h2);
    wr(8'h98, 8'h03);
    pulse(3'h1, 16, 32'h0);
    wr(8'hA8, 8'h01);
    pulse(3'h1, 16, 32'h1);
    wr(8'hB0, 8'h03);
    wr(8'hB4, 8'h06);
    wr(8'hA8, 8'h00);
    wr(8'hB0, 8'h02);
    wr(8'hA8, 8'h01);
    wr(8'hA8, 8'h00);
    pulse(3'h1, 16, 32'h0);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rdr(8'hB0);
    chk(rd, 32'h0);
    rdr(8'hC0);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic test_done();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      test_done();
    end
  end

  initial
  begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_axes();
    t_limit();
    t_latency();
    t_modes();
    test_done();
  end
endmodule
